// ==== bpf_defs.vh ====
// constants for the block-receive and isochronous-transmit packet framer
`ifndef BPF_DEFS_VH
`define BPF_DEFS_VH
// ****************************************
// transaction codes
// ****************************************
`define BPF_TC_WR_BLK     4'h1
`define BPF_TC_WR_RESP    4'h2
`define BPF_TC_RD_BLK     4'h5
`define BPF_TC_RD_RESP    4'h7
`define BPF_TC_LOCK_REQ   4'h9
`define BPF_TC_ISO        4'hA
`define BPF_TC_LOCK_RESP  4'hB
// ****************************************
// retry and speed codes
// ****************************************
`define BPF_RT_NEW        2'h0
`define BPF_RT_RETRY_X    2'h1
`define BPF_RT_PHASE_A    2'h2
`define BPF_RT_PHASE_B    2'h3
`define BPF_SPD_100       2'h0
`define BPF_SPD_200       2'h1
`define BPF_SPD_400       2'h2
// ****************************************
// field values and widths
// ****************************************
`define BPF_PRIO_CABLE    4'h0
`define BPF_RCODE_W       4
`define BPF_QUAD_BYTES    16'h0004
// ****************************************
// status quadlet fields (lsb-0 numbering)
// ****************************************
`define BPF_ST_SPD        17:16
`define BPF_ST_ACK        3:0
// ****************************************
// isochronous transmit header fields
// ****************************************
`define BPF_ISO_LEN       31:16
`define BPF_ISO_TAG       15:14
`define BPF_ISO_CHAN      13:8
`define BPF_ISO_SPD       7:6
`define BPF_ISO_SY        3:0
`endif

// ==== bpf_byte_packer.v ====
// packs a byte stream into quadlets, byte 0 in the top lane, zero padded
module bpf_byte_packer (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        in_valid,
  input  wire [7:0]  in_byte,
  input  wire        in_last,
  output wire        in_ready,
  output wire        out_valid,
  output wire [31:0] out_data,
  input  wire        out_ready
);
  reg  [31:0] word_r;
  reg  [1:0]  lane_r;
  reg         full_r;

  // no new byte while a finished quadlet waits
  assign in_ready  = !full_r;
  assign out_valid = full_r;
  assign out_data  = word_r;

  // ****************************************
  // lane fill
  // ****************************************
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      word_r <= 32'h0000_0000;
      lane_r <= 2'h0;
      full_r <= 1'b0;
    end
    else if (full_r)
    begin
      // clear so unused lanes read zero
      if (out_ready)
      begin
        full_r <= 1'b0;
        word_r <= 32'h0000_0000;
      end
    end
    else if (in_valid)
    begin
      // first byte lands in lane 0
      word_r[8'd31 - {lane_r, 3'b000} -: 8] <= in_byte;
      lane_r <= in_last ? 2'h0 : lane_r + 2'h1;
      full_r <= in_last || (lane_r == 2'h3);
    end
  end
endmodule // bpf_byte_packer

// ==== bpf_quad_unpacker.v ====
// splits one quadlet into up to four bytes, top lane first
module bpf_quad_unpacker (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        load,
  input  wire [31:0] load_quad,
  input  wire [2:0]  load_count,
  output wire        busy,
  output wire        out_valid,
  output wire [7:0]  out_byte,
  input  wire        out_ready
);
  reg  [31:0] shift_r;
  reg  [2:0]  left_r;

  assign busy      = (left_r != 3'h0);
  assign out_valid = busy;
  assign out_byte  = shift_r[31:24];

  // ****************************************
  // byte shifter
  // ****************************************
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_r <= 32'h0000_0000;
      left_r  <= 3'h0;
    end
    else if (load && !busy)
    begin
      shift_r <= load_quad;
      left_r  <= load_count;
    end
    else if (busy && out_ready)
    begin
      // pad lanes beyond the count are never shown
      shift_r <= {shift_r[23:0], 8'h00};
      left_r  <= left_r - 3'h1;
    end
  end
endmodule // bpf_quad_unpacker

// ==== bpf_framer.v ====
// block-receive and isochronous-transmit packet framer
// Behaviour
// - destination id is bus then node
// - transaction label passed to host
// - retry code new, x, phase a, b
// - priority zero on cable bus
// - destination offset forced quadlet aligned
// - lock response keeps top four code bits
// - length counts block data bytes only
// - write response length forced to zero
// - extended code passed with packet
// - first data byte in lane zero
// - final data quadlet zero padded
// - speed code 100, 200, 400 Mb/s
// - status holds the acknowledge we returned
// - send waiting iso packets after cycle start
// - iso length is payload byte count
// - iso packet sent at header speed
// - sync bits transmitted unchanged
// - header quadlets carry ids and control
// - no data for read request, write response
// - status quadlet follows every packet
`include "bpf_defs.vh"
module bpf_framer (
  input  wire        clk,
  input  wire        reset_n,
  // parsed header from the bus receiver
  input  wire        rx_hdr_valid,
  output wire        rx_hdr_ready,
  input  wire [9:0]  rx_dest_bus,
  input  wire [5:0]  rx_dest_node,
  input  wire [5:0]  rx_tlabel,
  input  wire [1:0]  rx_retry,
  input  wire [3:0]  rx_tcode,
  input  wire [3:0]  rx_priority,
  input  wire [15:0] rx_src_id,
  input  wire [15:0] rx_offset_hi,
  input  wire [31:0] rx_offset_lo,
  input  wire [15:0] rx_data_len,
  input  wire [15:0] rx_ext_tcode,
  // block data bytes from the bus receiver
  input  wire        rx_byte_valid,
  output wire        rx_byte_ready,
  input  wire [7:0]  rx_byte,
  // reception status from the bus receiver
  input  wire        rx_stat_valid,
  output wire        rx_stat_ready,
  input  wire [1:0]  rx_speed,
  input  wire [3:0]  ack_returned,
  // receive fifo write side
  output wire        rf_valid,
  input  wire        rf_ready,
  output wire [31:0] rf_data,
  // isochronous transmit fifo read side
  input  wire        itx_valid,
  output wire        itx_ready,
  input  wire [31:0] itx_data,
  // cycle start seen or sent on the bus
  input  wire        cycle_start,
  // toward the bus transmitter
  output wire        tx_start,
  output wire [15:0] tx_len,
  output wire [1:0]  tx_tag,
  output wire [5:0]  tx_chan,
  output wire [3:0]  tx_tcode,
  output wire [1:0]  tx_speed,
  output wire [3:0]  tx_sy,
  output wire        tx_byte_valid,
  input  wire        tx_byte_ready,
  output wire [7:0]  tx_byte,
  output wire        tx_last,
  output wire        tx_window
);
  // ****************************************
  // helpers
  // ****************************************
  // block packets whose data field is present
  function has_data;
    input [3:0] tc;
    begin
      has_data = (tc == `BPF_TC_WR_BLK) || (tc == `BPF_TC_RD_RESP) ||
                 (tc == `BPF_TC_LOCK_REQ) || (tc == `BPF_TC_LOCK_RESP);
    end
  endfunction

  // quadlets covering a byte count, rounded up
  function [15:0] quads_of;
    input [15:0] bytes;
    reg   [16:0] sum;
    begin
      sum      = {1'b0, bytes} + 17'h00003;
      quads_of = {1'b0, sum[16:2]};
    end
  endfunction

  // ****************************************
  // receive side state
  // ****************************************
  localparam [2:0] RX_IDLE = 3'h0;
  localparam [2:0] RX_H1   = 3'h1;
  localparam [2:0] RX_H2   = 3'h2;
  localparam [2:0] RX_H3   = 3'h3;
  localparam [2:0] RX_H4   = 3'h4;
  localparam [2:0] RX_DATA = 3'h5;
  localparam [2:0] RX_STAT = 3'h6;

  reg  [2:0]  rx_state_r;
  reg  [2:0]  rx_state_nxt;
  reg  [31:0] hq1_r;
  reg  [31:0] hq2_r;
  reg  [31:0] hq3_r;
  reg  [31:0] hq4_r;
  reg  [15:0] bytes_left_r;
  reg  [15:0] quads_left_r;
  reg         rf_valid_r;
  reg  [31:0] rf_data_r;
  reg         rf_load;
  reg  [31:0] rf_word;
  wire        can_load;
  wire        pk_valid;
  wire [31:0] pk_data;
  wire        pk_in_ready;
  wire        pk_take;
  wire        hdr_take;
  wire        stat_take;

  // output stage frees when empty or drained
  assign can_load      = !rf_valid_r || rf_ready;
  assign rf_valid      = rf_valid_r;
  assign rf_data       = rf_data_r;
  assign rx_hdr_ready  = (rx_state_r == RX_IDLE);
  assign hdr_take      = rx_hdr_valid && rx_hdr_ready;
  assign rx_stat_ready = (rx_state_r == RX_STAT) && can_load;
  assign stat_take     = rx_stat_valid && rx_stat_ready;
  assign pk_take       = (rx_state_r == RX_DATA) && can_load && pk_valid;
  // bytes past the stated length are held off
  assign rx_byte_ready = (rx_state_r == RX_DATA) && pk_in_ready &&
                         (bytes_left_r != 16'h0000);

  bpf_byte_packer u_packer (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (rx_byte_valid && rx_byte_ready),
    .in_byte   (rx_byte),
    .in_last   (bytes_left_r == 16'h0001),
    .in_ready  (pk_in_ready),
    .out_valid (pk_valid),
    .out_data  (pk_data),
    .out_ready (pk_take)
  );

  // ****************************************
  // header capture
  // ****************************************
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hq1_r <= 32'h0000_0000;
      hq2_r <= 32'h0000_0000;
      hq3_r <= 32'h0000_0000;
      hq4_r <= 32'h0000_0000;
    end
    else if (hdr_take)
    begin
      hq1_r <= {rx_dest_bus, rx_dest_node, rx_tlabel, rx_retry,
                rx_tcode, `BPF_PRIO_CABLE};
      if (rx_tcode == `BPF_TC_LOCK_RESP)
        hq2_r <= {rx_src_id, rx_offset_hi[15:12], 12'h000};
      else
        hq2_r <= {rx_src_id, rx_offset_hi};
      hq3_r <= {rx_offset_lo[31:2], 2'b00};
      if (rx_tcode == `BPF_TC_WR_RESP)
        hq4_r <= {16'h0000, rx_ext_tcode};
      else
        hq4_r <= {rx_data_len, rx_ext_tcode};
    end
  end

  // ****************************************
  // data byte and quadlet counters
  // ****************************************
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bytes_left_r <= 16'h0000;
      quads_left_r <= 16'h0000;
    end
    else if (hdr_take)
    begin
      // read request, write response: no data
      if (has_data(rx_tcode))
      begin
        bytes_left_r <= rx_data_len;
        quads_left_r <= quads_of(rx_data_len);
      end
      else
      begin
        bytes_left_r <= 16'h0000;
        quads_left_r <= 16'h0000;
      end
    end
    else
    begin
      if (rx_byte_valid && rx_byte_ready)
        bytes_left_r <= bytes_left_r - 16'h0001;
      if (pk_take)
        quads_left_r <= quads_left_r - 16'h0001;
    end
  end

  // ****************************************
  // receive sequencer, next state and word
  // ****************************************
  always @*
  begin
    rx_state_nxt = rx_state_r;
    rf_load      = 1'b0;
    rf_word      = 32'h0000_0000;
    case (rx_state_r)
      RX_IDLE:
        if (hdr_take)
          rx_state_nxt = RX_H1;
      RX_H1:
        if (can_load)
        begin
          rf_load      = 1'b1;
          rf_word      = hq1_r;
          rx_state_nxt = RX_H2;
        end
      RX_H2:
        if (can_load)
        begin
          rf_load      = 1'b1;
          rf_word      = hq2_r;
          rx_state_nxt = RX_H3;
        end
      RX_H3:
        if (can_load)
        begin
          rf_load      = 1'b1;
          rf_word      = hq3_r;
          rx_state_nxt = RX_H4;
        end
      RX_H4:
        if (can_load)
        begin
          rf_load      = 1'b1;
          rf_word      = hq4_r;
          rx_state_nxt = (quads_left_r == 16'h0000) ? RX_STAT : RX_DATA;
        end
      RX_DATA:
        if (pk_take)
        begin
          rf_load = 1'b1;
          rf_word = pk_data;
          if (quads_left_r == 16'h0001)
            rx_state_nxt = RX_STAT;
        end
      RX_STAT:
        if (stat_take)
        begin
          rf_load = 1'b1;
          rf_word[`BPF_ST_SPD] = rx_speed;
          rf_word[`BPF_ST_ACK] = ack_returned;
          rx_state_nxt = RX_IDLE;
        end
      default:
        rx_state_nxt = RX_IDLE;
    endcase
  end

  // ****************************************
  // receive state and fifo word register
  // ****************************************
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_state_r <= RX_IDLE;
      rf_valid_r <= 1'b0;
      rf_data_r  <= 32'h0000_0000;
    end
    else
    begin
      rx_state_r <= rx_state_nxt;
      if (rf_load)
      begin
        rf_valid_r <= 1'b1;
        rf_data_r  <= rf_word;
      end
      else if (rf_ready)
        rf_valid_r <= 1'b0;
    end
  end

  // ****************************************
  // isochronous transmit side
  // ****************************************
  localparam [1:0] TX_IDLE = 2'h0;
  localparam [1:0] TX_DATA = 2'h1;
  localparam [1:0] TX_END  = 2'h2;

  reg  [1:0]  tx_state_r;
  reg         window_r;
  reg         tx_start_r;
  reg  [15:0] tx_len_r;
  reg  [1:0]  tx_tag_r;
  reg  [5:0]  tx_chan_r;
  reg  [1:0]  tx_speed_r;
  reg  [3:0]  tx_sy_r;
  reg  [15:0] tx_left_r;
  reg  [15:0] tx_unsent_r;
  wire        up_busy;
  wire        up_load;
  wire        itx_take;
  wire [2:0]  up_count;

  assign tx_start  = tx_start_r;
  assign tx_len    = tx_len_r;
  assign tx_tag    = tx_tag_r;
  assign tx_chan   = tx_chan_r;
  assign tx_tcode  = `BPF_TC_ISO;
  assign tx_speed  = tx_speed_r;
  assign tx_sy     = tx_sy_r;
  assign tx_window = window_r;
  // header taken only inside a cycle window, payload while bytes remain
  assign itx_ready = ((tx_state_r == TX_IDLE) && window_r) ||
                     ((tx_state_r == TX_DATA) && !up_busy &&
                      (tx_left_r != 16'h0000));
  assign itx_take  = itx_valid && itx_ready;
  assign up_load   = itx_take && (tx_state_r == TX_DATA);
  // last quadlet may carry fewer than four payload bytes
  assign up_count  = (tx_left_r >= `BPF_QUAD_BYTES) ? 3'h4 : tx_left_r[2:0];
  // only the byte that empties the unsent count is last
  assign tx_last   = tx_byte_valid && (tx_unsent_r == 16'h0001);

  bpf_quad_unpacker u_unpacker (
    .clk        (clk),
    .reset_n    (reset_n),
    .load       (up_load),
    .load_quad  (itx_data),
    .load_count (up_count),
    .busy       (up_busy),
    .out_valid  (tx_byte_valid),
    .out_byte   (tx_byte),
    .out_ready  (tx_byte_ready)
  );

  // ****************************************
  // cycle window
  // ****************************************
  // open on cycle start, shut once the queue runs dry between packets;
  // a cycle start in the closing cycle wins
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      window_r <= 1'b0;
    else if (cycle_start)
      window_r <= 1'b1;
    else if ((tx_state_r == TX_IDLE) && !itx_valid)
      window_r <= 1'b0;
  end

  // ****************************************
  // transmit sequencer
  // ****************************************
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_state_r <= TX_IDLE;
      tx_start_r <= 1'b0;
      tx_len_r   <= 16'h0000;
      tx_tag_r   <= 2'h0;
      tx_chan_r  <= 6'h00;
      tx_speed_r <= `BPF_SPD_100;
      tx_sy_r    <= 4'h0;
      tx_left_r  <= 16'h0000;
      tx_unsent_r <= 16'h0000;
    end
    else
    begin
      tx_start_r <= 1'b0;
      if (tx_byte_valid && tx_byte_ready)
        tx_unsent_r <= tx_unsent_r - 16'h0001;
      case (tx_state_r)
        TX_IDLE:
          if (itx_take)
          begin
            tx_len_r   <= itx_data[`BPF_ISO_LEN];
            tx_left_r  <= itx_data[`BPF_ISO_LEN];
            tx_unsent_r <= itx_data[`BPF_ISO_LEN];
            tx_tag_r   <= itx_data[`BPF_ISO_TAG];
            tx_chan_r  <= itx_data[`BPF_ISO_CHAN];
            tx_speed_r <= itx_data[`BPF_ISO_SPD];
            tx_sy_r    <= itx_data[`BPF_ISO_SY];
            tx_start_r <= 1'b1;
            tx_state_r <= TX_DATA;
          end
        TX_DATA:
          if (up_load)
            tx_left_r <= tx_left_r - {13'h0000, up_count};
          else if (!up_busy && (tx_left_r == 16'h0000))
            tx_state_r <= TX_END;
        TX_END:
          tx_state_r <= TX_IDLE;
        default:
          tx_state_r <= TX_IDLE;
      endcase
    end
  end
endmodule // bpf_framer

// ==== bpf_framer_sva.sv ====
// assertion checker for the packet framer ports
module bpf_framer_sva (
  input logic        clk,
  input logic        reset_n,
  input logic        rx_hdr_valid,
  input logic        rx_hdr_ready,
  input logic        rx_stat_valid,
  input logic        rx_stat_ready,
  input logic [1:0]  rx_speed,
  input logic [3:0]  ack_returned,
  input logic        rf_valid,
  input logic        rf_ready,
  input logic [31:0] rf_data,
  input logic [31:0] itx_data,
  input logic        cycle_start,
  input logic        tx_start,
  input logic [15:0] tx_len,
  input logic [1:0]  tx_tag,
  input logic [5:0]  tx_chan,
  input logic [1:0]  tx_speed,
  input logic [3:0]  tx_sy,
  input logic        tx_byte_valid,
  input logic        tx_byte_ready,
  input logic [7:0]  tx_byte,
  input logic        tx_last,
  input logic        tx_window
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] itx_d;
  // last fifo word, so header fields can be tied to the word taken
  always @(posedge clk)
    itx_d <= itx_data;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ****************************************
  // receive side
  // ****************************************
  chk_hdr_busy: assert property (rx_hdr_valid && rx_hdr_ready |=> !rx_hdr_ready)
    else $error("second header accepted");
  chk_hdr_answer: assert property (rx_hdr_valid && rx_hdr_ready |-> ##[2:12] rf_valid)
    else $error("no header word after header");
  chk_status_word: assert property (rx_stat_valid && rx_stat_ready |=> rf_valid &&
    rf_data == {14'h0000, $past(rx_speed), 12'h000, $past(ack_returned)})
    else $error("bad status word");
  chk_rf_hold: assert property (rf_valid && !rf_ready |=> rf_valid && $stable(rf_data))
    else $error("receive word dropped while stalled");
  // ****************************************
  // isochronous side
  // ****************************************
  chk_window_open: assert property (cycle_start |=> tx_window)
    else $error("window not opened");
  chk_start_window: assert property (tx_start |-> $past(tx_window))
    else $error("packet started outside window");
  chk_start_fields: assert property (tx_start |->
    {tx_len, tx_tag, tx_chan, tx_speed, tx_sy} == {itx_d[31:6], itx_d[3:0]})
    else $error("header fields differ from word taken");
  chk_fields_hold: assert property (tx_byte_valid |-> $stable({tx_len, tx_speed, tx_sy}))
    else $error("header fields moved in payload");
  chk_byte_hold: assert property (tx_byte_valid && !tx_byte_ready |=>
    tx_byte_valid && $stable(tx_byte) && tx_last == $past(tx_last))
    else $error("byte changed while stalled");
  chk_last_valid: assert property (tx_last |-> tx_byte_valid)
    else $error("last mark without byte");
endmodule // bpf_framer_sva

// ==== bpf_host_model.sv ====
// host bus model: fills the iso fifo, drains the receive fifo
module bpf_host_model (
  input  logic        clk,
  input  logic        reset_n,
  input  logic        slow,
  input  logic        rf_valid,
  input  logic [31:0] rf_data,
  output logic        rf_ready,
  input  logic        itx_ready,
  output logic        itx_valid,
  output logic [31:0] itx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] itx_q[$];
  logic [31:0] rf_q[$];
  logic        tgl;
  // quiet outputs at time zero
  initial
  begin
    rf_ready = 1'b0;
    itx_valid = 1'b0;
    itx_data = 32'h0;
    tgl = 1'b0;
  end
  // ****************************************
  // receive fifo drain
  // ****************************************
  // slow mode refuses every other cycle to stall the framer
  always @(posedge clk)
  begin
    if (rf_valid && rf_ready)
      rf_q.push_back(rf_data);
    #1;
    tgl = ~tgl;
    rf_ready = reset_n && !(slow && tgl);
  end
  // ****************************************
  // iso fifo fill
  // ****************************************
  // strict queue order
  // idle data toggles so a stale word never looks valid
  always @(posedge clk)
  begin
    if (itx_valid && itx_ready)
      void'(itx_q.pop_front());
    #1;
    itx_valid = reset_n && itx_q.size() > 0;
    itx_data = itx_valid ? itx_q[0] : ~itx_data;
  end
endmodule // bpf_host_model

// ==== tb.sv ====
// self-checking testbench for the packet framer
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset_n, rx_hdr_valid, rx_byte_valid, rx_stat_valid, cycle_start, tx_byte_ready, slow;
  logic [9:0]  rx_dest_bus;
  logic [5:0]  rx_dest_node, rx_tlabel;
  logic [1:0]  rx_retry, rx_speed;
  logic [3:0]  rx_tcode, rx_priority, ack_returned;
  logic [15:0] rx_src_id, rx_offset_hi, rx_data_len, rx_ext_tcode;
  logic [31:0] rx_offset_lo;
  logic [7:0]  rx_byte;
  wire         rx_hdr_ready, rx_byte_ready, rx_stat_ready, rf_valid, rf_ready, itx_valid, itx_ready;
  wire         tx_start, tx_byte_valid, tx_last, tx_window;
  wire  [31:0] rf_data, itx_data;
  wire  [15:0] tx_len;
  wire  [5:0]  tx_chan;
  wire  [3:0]  tx_tcode, tx_sy;
  wire  [1:0]  tx_tag, tx_speed;
  wire  [7:0]  tx_byte;
  int          err_count, check_count, cyc;
  logic [31:0] exp_q[$], last_q[$];
  logic [29:0] hdr_q[$];
  logic [7:0]  txb_q[$];
  bpf_framer uut (.clk(clk), .reset_n(reset_n), .rx_hdr_valid(rx_hdr_valid), .rx_hdr_ready(rx_hdr_ready),
    .rx_dest_bus(rx_dest_bus), .rx_dest_node(rx_dest_node), .rx_tlabel(rx_tlabel), .rx_retry(rx_retry),
    .rx_tcode(rx_tcode), .rx_priority(rx_priority), .rx_src_id(rx_src_id), .rx_offset_hi(rx_offset_hi),
    .rx_offset_lo(rx_offset_lo), .rx_data_len(rx_data_len), .rx_ext_tcode(rx_ext_tcode),
    .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready), .rx_byte(rx_byte),
    .rx_stat_valid(rx_stat_valid), .rx_stat_ready(rx_stat_ready), .rx_speed(rx_speed),
    .ack_returned(ack_returned), .rf_valid(rf_valid), .rf_ready(rf_ready), .rf_data(rf_data),
    .itx_valid(itx_valid), .itx_ready(itx_ready), .itx_data(itx_data), .cycle_start(cycle_start),
    .tx_start(tx_start), .tx_len(tx_len), .tx_tag(tx_tag), .tx_chan(tx_chan), .tx_tcode(tx_tcode),
    .tx_speed(tx_speed), .tx_sy(tx_sy), .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
    .tx_byte(tx_byte), .tx_last(tx_last), .tx_window(tx_window));
  bpf_host_model host (.clk(clk), .reset_n(reset_n), .slow(slow), .rf_valid(rf_valid), .rf_data(rf_data),
    .rf_ready(rf_ready), .itx_ready(itx_ready), .itx_valid(itx_valid), .itx_data(itx_data));
  // 10 MHz clock
  initial clk = 1'b0;
  always #50 clk = ~clk;
  // ****************************************
  // transmit monitor and hang guard
  // ****************************************
  // transmitter stalls every other cycle to exercise holding
  always @(posedge clk)
  begin
    cyc++;
    if (tx_start)
      hdr_q.push_back({tx_len, tx_tag, tx_chan, tx_speed, tx_sy});
    if (tx_byte_valid && tx_byte_ready)
      txb_q.push_back(tx_byte);
    if (tx_byte_valid && tx_byte_ready && tx_last)
      last_q.push_back(txb_q.size());
    #1 tx_byte_ready = ~tx_byte_ready;
    if (cyc > 20000)
    begin
      err_count++;
      complete_run();
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one block packet in, expected fifo words built from the field values
  task automatic run_blk(input logic [3:0] tc, input logic [15:0] len, input logic [1:0] rt, input logic [1:0] spd);
    int          nb;
    logic [31:0] w;
    nb = (tc == 4'h1 || tc == 4'h7 || tc == 4'h9 || tc == 4'hB) ? len : 0;
    exp_q = {};
    exp_q.push_back({rx_dest_bus, rx_dest_node, rx_tlabel, rt, tc, 4'h0});
    exp_q.push_back({rx_src_id, tc == 4'hB ? {rx_offset_hi[15:12], 12'h000} : rx_offset_hi});
    exp_q.push_back({rx_offset_lo[31:2], 2'b00});
    exp_q.push_back({tc == 4'h2 ? 16'h0000 : len, rx_ext_tcode});
    for (int q = 0; q < (nb + 3) / 4; q++)
    begin
      w = 32'h0;
      for (int b = 0; b < 4; b++)
        if (q * 4 + b < nb)
          w[31 - 8 * b -: 8] = 8'hA0 + 8'(q * 4 + b);
      exp_q.push_back(w);
    end
    exp_q.push_back({14'h0000, spd, 12'h000, ack_returned});
    rx_tcode = tc;
    rx_data_len = len;
    rx_retry = rt;
    rx_hdr_valid = 1'b1;
    do @(posedge clk); while (!rx_hdr_ready);
    #1 rx_hdr_valid = 1'b0;
    rx_byte_valid = nb > 0;
    for (int k = 0; k < nb; k++)
    begin
      rx_byte = 8'hA0 + 8'(k);
      do @(posedge clk); while (!rx_byte_ready);
      #1;
    end
    rx_byte_valid = 1'b0;
    rx_byte = ~rx_byte;
    rx_speed = spd;
    rx_stat_valid = 1'b1;
    do @(posedge clk); while (!rx_stat_ready);
    #1 rx_stat_valid = 1'b0;
    rx_speed = ~rx_speed;
    while (host.rf_q.size() < exp_q.size())
      @(posedge clk);
    repeat (3) @(posedge clk);
    #1 chk(host.rf_q.size(), exp_q.size());
    foreach (exp_q[i])
      chk(host.rf_q[i], exp_q[i]);
    host.rf_q = {};
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_codes;
    for (int i = 0; i < 4; i++)
    begin
      ack_returned = 4'h1 + 4'(i);
      run_blk(4'h1, 16'(i + 1), 2'(i), 2'(i % 3));
    end
  endtask
  task automatic s_kinds;
    run_blk(4'hB, 16'h0008, 2'h0, 2'h2);
    run_blk(4'h9, 16'h0003, 2'h1, 2'h1);
    run_blk(4'h7, 16'h0006, 2'h2, 2'h0);
    run_blk(4'h5, 16'h0010, 2'h3, 2'h1);
    run_blk(4'h2, 16'h0007, 2'h0, 2'h2);
  endtask
  task automatic s_slow;
    slow = 1'b1;
    run_blk(4'h1, 16'h0009, 2'h0, 2'h1);
    slow = 1'b0;
  endtask
  task automatic s_iso;
    logic [7:0] eb[8] = '{8'h31, 8'h32, 8'h33, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45};
    host.itx_q.push_back({16'h0003, 2'b00, 6'h15, 2'h1, 2'b00, 4'h9});
    host.itx_q.push_back(32'h3132_3300);
    host.itx_q.push_back({16'h0005, 2'b00, 6'h2A, 2'h2, 2'b00, 4'h6});
    host.itx_q.push_back(32'h4142_4344);
    host.itx_q.push_back(32'h4500_0000);
    repeat (10) @(posedge clk);
    chk(hdr_q.size(), 32'h0);
    #1 cycle_start = 1'b1;
    @(posedge clk);
    #1 cycle_start = 1'b0;
    while (txb_q.size() < 8)
      @(posedge clk);
    repeat (6) @(posedge clk);
    #1 chk(hdr_q.size(), 32'h2);
    chk(hdr_q[0], {16'h0003, 2'b00, 6'h15, 2'h1, 4'h9});
    chk(hdr_q[1], {16'h0005, 2'b00, 6'h2A, 2'h2, 4'h6});
    for (int k = 0; k < 8; k++)
      chk(txb_q[k], eb[k]);
    chk(last_q[0], 32'h3);
    chk(last_q[1], 32'h8);
    chk(tx_tcode, 4'hA);
    chk(tx_window, 1'b0);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {rx_hdr_valid, rx_byte_valid, rx_stat_valid, cycle_start, tx_byte_ready, slow} = 6'h00;
    {rx_retry, rx_speed, rx_tcode, rx_data_len, rx_byte} = 32'h0;
    rx_dest_bus = 10'h2A5;
    rx_dest_node = 6'h13;
    rx_tlabel = 6'h2C;
    rx_priority = 4'h7;
    rx_src_id = 16'hC3D4;
    rx_offset_hi = 16'hFFFF;
    rx_offset_lo = 32'h1234_5677;
    rx_ext_tcode = 16'h0C0D;
    ack_returned = 4'h1;
    reset_n = 1'b0;
    repeat (6) @(posedge clk);
    #1 reset_n = 1'b1;
    s_codes();
    s_kinds();
    s_slow();
    s_iso();
    complete_run();
  end
endmodule // tb
bind bpf_framer bpf_framer_sva chk (.clk(clk), .reset_n(reset_n), .rx_hdr_valid(rx_hdr_valid),
  .rx_hdr_ready(rx_hdr_ready), .rx_stat_valid(rx_stat_valid), .rx_stat_ready(rx_stat_ready),
  .rx_speed(rx_speed), .ack_returned(ack_returned), .rf_valid(rf_valid), .rf_ready(rf_ready),
  .rf_data(rf_data), .itx_data(itx_data), .cycle_start(cycle_start), .tx_start(tx_start), .tx_len(tx_len),
  .tx_tag(tx_tag), .tx_chan(tx_chan), .tx_speed(tx_speed), .tx_sy(tx_sy), .tx_byte_valid(tx_byte_valid),
  .tx_byte_ready(tx_byte_ready), .tx_byte(tx_byte), .tx_last(tx_last), .tx_window(tx_window));
